// [verilog/secured_region_host.sv]
/*
  Host controller for a parallel flash with a secured overlay region:
  Wishbone register slave, command step sequencer, overlay bookkeeping.
  Assumes a classic Wishbone master and a flash whose pins are wired directly.
*/
module secured_region_host
#(
  parameter int unsigned SETTLE_CYCLES = sec_guard_pkg::SUPPLY_SETTLE_CYC
)
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [sec_guard_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic [31:0]                            wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire logic                              supply_ok,
  output logic [sec_guard_pkg::ADDR_W-1:0]       flash_addr,
  output logic [sec_guard_pkg::DATA_W-1:0]       flash_dq_o,
  input  wire logic [sec_guard_pkg::DATA_W-1:0]  flash_dq_i,
  output logic                                   flash_dq_oe,
  output logic                                   flash_ce_n,
  output logic                                   flash_we_n,
  output logic                                   flash_oe_n,
  output logic                                   flash_reset_n,
  output logic                                   flash_byte_n
);
  import sec_guard_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_CYCLE = 2'b10,
    S_RESET = 2'b11
  } seq_state_t;

  logic              ack_q;
  logic [31:0]       dat_q;
  logic [ADDR_W-1:0] addr_reg_q;
  logic [DATA_W-1:0] wdata_reg_q;
  logic [DATA_W-1:0] rdata_reg_q;
  logic [31:0]       cfg_q;
  op_t               op_q;
  seq_state_t        state_q;
  logic [4:0]        pc_q;
  logic              overlay_q;
  logic              need_exit_q;
  logic              ind_valid_q;
  logic              ind_bit_q;
  logic              refused_q;
  logic              cyc_start_q;
  logic              cyc_write_q;
  logic [ADDR_W-1:0] cyc_addr_q;
  logic [DATA_W-1:0] cyc_wdata_q;
  logic              byte_n_q;
  logic              reset_req_q;

  logic              power_ok;
  logic              reset_done;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic              bus_wr;
  logic              ctrl_wr;
  logic [31:0]       byte_mask;
  op_t               new_op;
  logic              accept;
  step_t             step;
  logic [ADDR_W-1:0] cmd_addr;

  flash_power_guard #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_guard (
    .clk           (clk),
    .rst           (rst),
    .supply_ok     (supply_ok),
    .reset_req     (reset_req_q),
    .power_ok      (power_ok),
    .flash_reset_n (flash_reset_n),
    .reset_done    (reset_done)
  );

  // Losing the supply drops any cycle in flight and parks the pins idle
  flash_bus_cycle u_cycle (
    .clk       (clk),
    .rst       (rst || !power_ok || !supply_ok),
    .start     (cyc_start_q),
    .write     (cyc_write_q),
    .addr      (cyc_addr_q),
    .wdata     (cyc_wdata_q),
    .dq_i      (flash_dq_i),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .pin_addr  (flash_addr),
    .pin_dq_o  (flash_dq_o),
    .pin_dq_oe (flash_dq_oe),
    .pin_ce_n  (flash_ce_n),
    .pin_we_n  (flash_we_n),
    .pin_oe_n  (flash_oe_n)
  );

  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign ctrl_wr = bus_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
  assign new_op  = op_t'(wb_dat_i[2:0]);
  assign step    = step_at(pc_q);
  // Command addresses are given in word units; byte mode doubles them
  assign cmd_addr = byte_n_q ? {10'h000, step.addr} : {9'h000, step.addr, 1'b0};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      byte_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
  end

  // Main-array work is refused until exit once the region has been locked
  always_comb
  begin
    accept = power_ok && (state_q == S_IDLE) && (new_op != OP_NONE);
    if (need_exit_q && (new_op == OP_READ || new_op == OP_PROGRAM))
      accept = 1'b0;
  end

  // Registered ack: one wait state, dropped after one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      dat_q <= '0;
    else if (wb_cyc_i && wb_stb_i && !ack_q)
    begin
      unique case (wb_adr_i)
        REG_CTRL:   dat_q <= {29'h0, op_q};
        REG_ADDR:   dat_q <= {10'h0, addr_reg_q};
        REG_WDATA:  dat_q <= {16'h0, wdata_reg_q};
        REG_RDATA:  dat_q <= {16'h0, rdata_reg_q};
        REG_STATUS: dat_q <= {25'h0, power_ok, refused_q, ind_bit_q, ind_valid_q,
                              need_exit_q, overlay_q, (state_q != S_IDLE)};
        REG_CFG:    dat_q <= cfg_q;
        default:    dat_q <= '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_reg_q  <= '0;
      wdata_reg_q <= '0;
      cfg_q       <= CFG_RESET;
    end
    else if (bus_wr)
    begin
      if (wb_adr_i == REG_ADDR)
        addr_reg_q <= ADDR_W'((wb_dat_i & byte_mask) | ({10'h0, addr_reg_q} & ~byte_mask));
      if (wb_adr_i == REG_WDATA)
        wdata_reg_q <= DATA_W'((wb_dat_i & byte_mask) | ({16'h0, wdata_reg_q} & ~byte_mask));
      if (wb_adr_i == REG_CFG)
        cfg_q <= (wb_dat_i & byte_mask & 32'h0000_0001) | (cfg_q & ~byte_mask);
    end
  end

  // Byte pin follows config only between operations, never mid-sequence
  always_ff @(posedge clk)
  begin
    if (rst)
      byte_n_q <= 1'b1;
    else if (state_q == S_IDLE)
      byte_n_q <= !cfg_q[CFG_BYTE_MODE];
  end

  // Refusal flag: each control write sets it if refused and clears it if accepted
  always_ff @(posedge clk)
  begin
    if (rst)
      refused_q <= 1'b0;
    else if (ctrl_wr)
      refused_q <= !accept;
  end

  // Sequencer: walks the step table for the current operation
  always_ff @(posedge clk)
  begin
    if (rst || !power_ok)
    begin
      state_q     <= S_IDLE;
      pc_q        <= '0;
      op_q        <= OP_NONE;
      cyc_start_q <= 1'b0;
      cyc_write_q <= 1'b0;
      cyc_addr_q  <= '0;
      cyc_wdata_q <= '0;
      reset_req_q <= 1'b0;
    end
    else
    begin
      cyc_start_q <= 1'b0;
      reset_req_q <= 1'b0;
      unique case (state_q)
        S_IDLE:
          if (ctrl_wr && accept)
          begin
            op_q    <= new_op;
            state_q <= S_FETCH;
            unique case (new_op)
              OP_ENTER:   pc_q <= PC_ENTER;
              OP_EXIT:    pc_q <= PC_EXIT;
              OP_PROGRAM: pc_q <= PC_PROGRAM;
              OP_READ:    pc_q <= PC_READ;
              OP_QUERY:   pc_q <= PC_QUERY;
              OP_LOCK:    pc_q <= PC_LOCK;
              default:    pc_q <= '0;
            endcase
            if (new_op == OP_HW_RESET)
            begin
              reset_req_q <= 1'b1;
              state_q     <= S_RESET;
            end
          end
        S_FETCH:
          if (step.kind == STEP_END)
            state_q <= S_IDLE;
          else
          begin
            // Programming uses the full unlocked sequence, no bypass form
            cyc_start_q <= 1'b1;
            cyc_write_q <= (step.kind == STEP_CMD) || (step.kind == STEP_USRWR);
            cyc_addr_q  <= (step.kind == STEP_USRWR || step.kind == STEP_USRRD)
                           ? addr_reg_q : cmd_addr;
            cyc_wdata_q <= (step.kind == STEP_USRWR) ? wdata_reg_q : {8'h00, step.data};
            state_q     <= S_CYCLE;
          end
        S_CYCLE:
          if (cyc_done)
          begin
            pc_q    <= pc_q + 5'h01;
            state_q <= S_FETCH;
          end
        S_RESET:
          if (reset_done)
            state_q <= S_IDLE;
      endcase
    end
  end

  // Read data capture; the indicator bit is taken from data line seven
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_reg_q <= '0;
      ind_valid_q <= 1'b0;
      ind_bit_q   <= 1'b0;
    end
    else if (state_q == S_CYCLE && cyc_done)
    begin
      if (step.kind == STEP_USRRD)
        rdata_reg_q <= cyc_rdata;
      if (step.kind == STEP_INDRD)
      begin
        rdata_reg_q <= cyc_rdata;
        ind_valid_q <= 1'b1;
        ind_bit_q   <= cyc_rdata[IND_DATA_BIT];
      end
    end
  end

  // Host-side view of the overlay, mirrors what the part does
  always_ff @(posedge clk)
  begin
    if (rst || !power_ok)
    begin
      overlay_q   <= 1'b0;
      need_exit_q <= 1'b0;
    end
    else if (state_q == S_RESET && reset_done)
    begin
      overlay_q   <= 1'b0;
      need_exit_q <= 1'b0;
    end
    else if (state_q == S_FETCH && step.kind == STEP_END)
    begin
      unique case (op_q)
        OP_ENTER: overlay_q <= 1'b1;
        OP_LOCK:
        begin
          overlay_q   <= 1'b1;
          need_exit_q <= 1'b1;
        end
        OP_EXIT:
        begin
          overlay_q   <= 1'b0;
          need_exit_q <= 1'b0;
        end
        default:
        begin
          overlay_q   <= overlay_q;
          need_exit_q <= need_exit_q;
        end
      endcase
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign flash_byte_n = byte_n_q;

endmodule

// [shared/sec_guard_pkg.sv]
/*
  Constants, types and command step table for the host controller that drives a
  parallel flash with a one-time-programmable secured region.
  Assumes a single 100 MHz clock and a device with asynchronous control pins.
*/
// Functional notes
// - Lock: enter sequence, then sector protect writes
// - Alternate protect method after enter also locks
// - Host issues exit before touching main array
// - Program only after host supplies unlock cycles
// - Write needs select and strobe low, output-enable high
// - Host holds pins write-safe until supply valid
package sec_guard_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 16;
  localparam int WB_AW  = 8;

  // Bus-side timing in nanoseconds, then rounded up to clock cycles
  localparam int CLK_PERIOD_NS    = 10;
  localparam int WE_LOW_NS        = 35;
  localparam int WE_HIGH_NS       = 20;
  localparam int READ_ACC_NS      = 70;
  localparam int RESET_LOW_NS     = 500;
  localparam int SUPPLY_SETTLE_NS = 50000;
  localparam int WE_LOW_CYC        = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC       = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACC_CYC      = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC     = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets (byte addresses)
  localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [WB_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [WB_AW-1:0] REG_WDATA  = 8'h08;
  localparam logic [WB_AW-1:0] REG_RDATA  = 8'h0c;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h10;
  localparam logic [WB_AW-1:0] REG_CFG    = 8'h14;

  // Status field positions, then config bit and indicator data line
  localparam int ST_BUSY      = 0;
  localparam int ST_OVERLAY   = 1;
  localparam int ST_NEED_EXIT = 2;
  localparam int ST_IND_VALID = 3;
  localparam int ST_IND_BIT   = 4;
  localparam int ST_REFUSED   = 5;
  localparam int ST_POWER_OK  = 6;
  localparam int CFG_BYTE_MODE = 0;
  localparam int IND_DATA_BIT  = 7;

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Command encodings; treated as settings of the part in use
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  ENTER_DATA   = 8'h88;
  localparam logic [7:0]  EXIT_DATA1   = 8'h90;
  localparam logic [7:0]  EXIT_DATA2   = 8'h00;
  localparam logic [7:0]  PROGRAM_DATA = 8'ha0;
  localparam logic [7:0]  QUERY_DATA   = 8'h90;
  localparam logic [11:0] IND_ADDR     = 12'h003;
  localparam logic [7:0]  RETURN_DATA  = 8'hf0;
  localparam logic [11:0] PROTECT_ADDR = 12'h002;
  localparam logic [7:0]  PROTECT_DATA = 8'h60;

  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_READ     = 3'b001,
    OP_PROGRAM  = 3'b010,
    OP_ENTER    = 3'b011,
    OP_EXIT     = 3'b100,
    OP_QUERY    = 3'b101,
    OP_LOCK     = 3'b110,
    OP_HW_RESET = 3'b111
  } op_t;

  typedef enum logic [2:0] {
    STEP_END   = 3'b000,
    STEP_CMD   = 3'b001,
    STEP_USRWR = 3'b010,
    STEP_USRRD = 3'b011,
    STEP_INDRD = 3'b100
  } step_kind_t;

  typedef struct packed {
    step_kind_t  kind;
    logic [11:0] addr;
    logic [7:0]  data;
  } step_t;

  localparam logic [4:0] PC_ENTER   = 5'h00;
  localparam logic [4:0] PC_EXIT    = 5'h04;
  localparam logic [4:0] PC_PROGRAM = 5'h09;
  localparam logic [4:0] PC_READ    = 5'h0e;
  localparam logic [4:0] PC_QUERY   = 5'h10;
  localparam logic [4:0] PC_LOCK    = 5'h16;

  function automatic step_t step_at(input logic [4:0] pc);
    case (pc)
      5'h00, 5'h04, 5'h09, 5'h10, 5'h16: step_at = '{STEP_CMD, UNLOCK1_ADDR, UNLOCK1_DATA};
      5'h01, 5'h05, 5'h0a, 5'h11, 5'h17: step_at = '{STEP_CMD, UNLOCK2_ADDR, UNLOCK2_DATA};
      5'h02, 5'h18: step_at = '{STEP_CMD, UNLOCK1_ADDR, ENTER_DATA};
      5'h06:        step_at = '{STEP_CMD, UNLOCK1_ADDR, EXIT_DATA1};
      5'h07:        step_at = '{STEP_CMD, 12'h000, EXIT_DATA2};
      5'h0b:        step_at = '{STEP_CMD, UNLOCK1_ADDR, PROGRAM_DATA};
      5'h0c:        step_at = '{STEP_USRWR, 12'h000, 8'h00};
      5'h0e:        step_at = '{STEP_USRRD, 12'h000, 8'h00};
      5'h12:        step_at = '{STEP_CMD, UNLOCK1_ADDR, QUERY_DATA};
      5'h13:        step_at = '{STEP_INDRD, IND_ADDR, 8'h00};
      5'h14:        step_at = '{STEP_CMD, 12'h000, RETURN_DATA};
      5'h19, 5'h1a: step_at = '{STEP_CMD, PROTECT_ADDR, PROTECT_DATA};
      default:      step_at = '{STEP_END, 12'h000, 8'h00};
    endcase
  endfunction

endpackage

// [verilog/flash_power_guard.sv]
/*
  Supply qualification and hardware reset pulse for the flash.
  Assumes supply_ok is a level synchronous to clk from a supervisor.
*/
module flash_power_guard
#(
  parameter int unsigned SETTLE_CYCLES = sec_guard_pkg::SUPPLY_SETTLE_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic supply_ok,
  input  wire logic reset_req,
  output logic      power_ok,
  output logic      flash_reset_n,
  output logic      reset_done
);
  import sec_guard_pkg::*;

  logic [CNT_W-1:0] settle_q;
  logic             power_ok_q;
  logic [CNT_W-1:0] pulse_cnt_q;
  logic             pulse_q;
  logic             done_q;
  logic             reset_n_q;

  // No bus cycle reaches the part until the supply has settled; the byte pin still follows config
  always_ff @(posedge clk)
  begin
    if (rst || !supply_ok)
    begin
      settle_q   <= '0;
      power_ok_q <= 1'b0;
    end
    else if (!power_ok_q)
    begin
      if (settle_q == CNT_W'(SETTLE_CYCLES - 1))
        power_ok_q <= 1'b1;
      else
        settle_q <= settle_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !supply_ok)
    begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= '0;
      done_q      <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (reset_req && !pulse_q)
      begin
        pulse_q     <= 1'b1;
        pulse_cnt_q <= CNT_W'(RESET_LOW_CYC - 1);
      end
      else if (pulse_q)
      begin
        if (pulse_cnt_q == '0)
        begin
          pulse_q <= 1'b0;
          done_q  <= 1'b1;
        end
        else
          pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  // Held low while the supply is unqualified so the part starts in read mode
  always_ff @(posedge clk)
  begin
    if (rst)
      reset_n_q <= 1'b0;
    else
      reset_n_q <= power_ok_q && !pulse_q;
  end

  assign power_ok      = power_ok_q;
  assign flash_reset_n = reset_n_q;
  assign reset_done    = done_q;

endmodule

// [verilog/flash_bus_cycle.sv]
/*
  One asynchronous flash bus cycle (read or write) with timed strobes.
  Assumes the caller holds start for one cycle while idle.
*/
module flash_bus_cycle
(
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             start,
  input  wire logic                             write,
  input  wire logic [sec_guard_pkg::ADDR_W-1:0] addr,
  input  wire logic [sec_guard_pkg::DATA_W-1:0] wdata,
  input  wire logic [sec_guard_pkg::DATA_W-1:0] dq_i,
  output logic                                  done,
  output logic [sec_guard_pkg::DATA_W-1:0]      rdata,
  output logic [sec_guard_pkg::ADDR_W-1:0]      pin_addr,
  output logic [sec_guard_pkg::DATA_W-1:0]      pin_dq_o,
  output logic                                  pin_dq_oe,
  output logic                                  pin_ce_n,
  output logic                                  pin_we_n,
  output logic                                  pin_oe_n
);
  import sec_guard_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE    = 2'b00,
    C_SETUP   = 2'b01,
    C_ACTIVE  = 2'b10,
    C_RECOVER = 2'b11
  } cyc_state_t;

  cyc_state_t       state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             wr_q;
  logic             done_q;
  logic [DATA_W-1:0] rdata_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dq_q;
  logic             dq_oe_q;
  logic             ce_n_q;
  logic             we_n_q;
  logic             oe_n_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= C_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
      addr_q  <= '0;
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (state_q)
        C_IDLE:
          if (start)
          begin
            wr_q    <= write;
            addr_q  <= addr;
            dq_q    <= wdata;
            dq_oe_q <= write;
            ce_n_q  <= 1'b0;
            oe_n_q  <= 1'b1;
            state_q <= C_SETUP;
          end
        C_SETUP:
        begin
          // Strobe lasts several cycles, far above the glitch filter width
          cnt_q   <= wr_q ? CNT_W'(WE_LOW_CYC - 1) : CNT_W'(READ_ACC_CYC - 1);
          we_n_q  <= !wr_q;
          oe_n_q  <= wr_q;
          state_q <= C_ACTIVE;
        end
        C_ACTIVE:
          if (cnt_q == '0)
          begin
            if (!wr_q)
              rdata_q <= dq_i;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            cnt_q   <= CNT_W'(WE_HIGH_CYC - 1);
            state_q <= C_RECOVER;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        C_RECOVER:
          // Select and data held through recovery: a select rising with the
          // strobe would leave the part's latching edge ambiguous
          if (cnt_q == '0)
          begin
            ce_n_q  <= 1'b1;
            dq_oe_q <= 1'b0;
            done_q  <= 1'b1;
            state_q <= C_IDLE;
          end
          else
            cnt_q <= cnt_q - 1'b1;
      endcase
    end
  end

  assign done      = done_q;
  assign rdata     = rdata_q;
  assign pin_addr  = addr_q;
  assign pin_dq_o  = dq_q;
  assign pin_dq_oe = dq_oe_q;
  assign pin_ce_n  = ce_n_q;
  assign pin_we_n  = we_n_q;
  assign pin_oe_n  = oe_n_q;

endmodule

// [verif/flash_model.sv]
/*
  Behavioural parallel flash with a secured overlay region (bottom-boot variant).
  Assumes host pins wired directly; factory selects the lock variant.
*/
module flash_model
(
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_o,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_n,
  input  wire logic        supply_ok,
  input  wire logic        factory,
  output logic      [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  sec [256];
  logic [1:0]  st;
  logic        ovl, qm, pgm, lck;
  logic [15:0] v;
  time         tf;
  task automatic wr(input logic [7:0] d);
    if (pgm)
    begin
      // Bits only clear: no erase path exists
      if (ovl && !lck && !factory) sec[addr[7:0]] &= d;
      pgm = 1'b0;
    end
    else if (d == 8'h55 && st == 2'd1) st = 2'd2;
    else if (d == 8'haa) st = 2'd1;
    else
    begin
      if (st == 2'd2 && d == 8'h88) ovl = 1'b1;
      if (st == 2'd2 && d == 8'h90) qm = 1'b1;
      if (st == 2'd2 && d == 8'ha0) pgm = 1'b1;
      if (d == 8'h60) lck |= ovl;
      if (d == 8'h00 && qm) ovl = 1'b0;
      if (d == 8'h00 || d == 8'hf0) qm = 1'b0;
      st = 2'd0;
    end
  endtask
  initial
  begin
    {st, ovl, qm, pgm, lck} = '0;
    for (int i = 0; i < 256; i++) sec[i] = 8'h50 ^ i[7:0]; // Serial at bottom
    // Top-boot serial sits at the same region offset, low address bits zero
  end
  always @(negedge we_n) tf = $time;
  always @(negedge supply_ok or negedge reset_n) {st, ovl, qm, pgm} = '0;
  // Unknown tf at power-up keeps the first rising edge harmless
  always @(posedge we_n)
    if (!ce_n && oe_n && supply_ok && reset_n && $time - tf >= 5) wr(dq_o[7:0]);
  assign v = (qm && addr[7:0] == 8'h03) ? {8'h00, factory, 7'h00}
           : ovl ? {8'h00, sec[addr[7:0]]} : addr[15:0];
  assign dq_i = (!ce_n && !oe_n) ? v : ~v;
endmodule

// [verif/secured_region_host_sva.sv]
/*
  Port checker for the secured region host controller.
  Assumes binding to the top module, one clock, reset rst.
*/
module secured_region_host_sva
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic supply_ok,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence we_pulse;
    !flash_we_n [*4] ##1 flash_we_n;
  endsequence
  sequence dq_hold;
    flash_dq_oe [*2];
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_write_gate: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("strobe low outside write");
  a_read_gate: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("bad read pins");
  a_strobe_width: assert property ($fell(flash_we_n) |-> we_pulse)
    else $error("strobe width wrong");
  a_select_setup: assert property ($fell(flash_we_n) |-> $past(flash_ce_n) == 1'b0)
    else $error("no select setup");
  a_data_hold: assert property ($rose(flash_we_n) |-> dq_hold)
    else $error("data released early");
  a_supply_safe: assert property (!supply_ok |=> flash_we_n && flash_oe_n)
    else $error("pins active on low supply");
endmodule

bind secured_region_host secured_region_host_sva i_sva (.*);

// [verif/testbench.sv]
/*
  Self-checking bench: host controller driving the flash model.
  Assumes register map and timing of the controller hand-over.
*/
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sec_guard_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, sok, fac, dq_oe, ce_n, we_n, oe_n, rn, bn;
  logic [7:0]  adr;
  logic [21:0] fa;
  logic [15:0] fdo, fdi;
  logic [31:0] dat, dat_o, rd;
  int          mismatches, samples_checked;
  secured_region_host #(.SETTLE_CYCLES(8)) i_secured_region_host
  (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .supply_ok(sok),
    .flash_addr(fa), .flash_dq_o(fdo), .flash_dq_i(fdi), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(rn),
    .flash_byte_n(bn)
  );
  flash_model i_flash_model
  (
    .addr(fa), .dq_o(fdo), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(rn),
    .supply_ok(sok), .factory(fac), .dq_i(fdi)
  );
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic run(input logic [2:0] o);
    wb(1'b1, REG_CTRL, {29'h0, o});
    do wb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
  endtask
  task automatic power_wait;
    do wb(1'b0, REG_STATUS, 32'h0); while (rd[ST_POWER_OK] !== 1'b1);
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] d);
    wb(1'b1, REG_ADDR, {10'h0, a});
    wb(1'b1, REG_WDATA, {16'h0, d});
    run(3'd2);
  endtask
  task automatic rdchk(input logic [21:0] a, input logic [15:0] e);
    wb(1'b1, REG_ADDR, {10'h0, a});
    run(3'd1);
    wb(1'b0, REG_RDATA, 32'h0);
    `CHK(rd[15:0], e)
  endtask
  task automatic t_early;
    `CHK(rn, 1'b0)
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[6:5], 2'b01)
    wb(1'b0, REG_CFG, 32'h0);
    `CHK(rd, CFG_RESET)
    `CHK(bn, 1'b1)
    wb(1'b1, REG_CFG, 32'h1);
    wb(1'b0, REG_CFG, 32'h0);
    `CHK({rd[0], bn}, 2'b10)
    wb(1'b1, REG_CFG, 32'h0);
    wb(1'b0, REG_CFG, 32'h0);
    `CHK({rd[0], bn}, 2'b01)
    wb(1'b1, 8'h18, 32'hffff);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0)
    power_wait();
  endtask
  task automatic t_query(input logic f);
    @(posedge clk);
    fac <= f;
    run(3'd5);
    `CHK(rd[ST_IND_BIT:ST_IND_VALID], {f, 1'b1})
  endtask
  task automatic t_factory;
    @(posedge clk);
    fac <= 1'b1;
    run(3'd3);
    prog(22'h13, 16'h0000);
    rdchk(22'h13, 16'h0043);
    run(3'd7);
    `CHK(rd[ST_OVERLAY], 1'b0)
    rdchk(22'h13, 16'h0013);
    fac <= 1'b0;
  endtask
  task automatic t_overlay;
    rdchk(22'h1234, 16'h1234);
    run(3'd3);
    `CHK(rd[ST_OVERLAY], 1'b1)
    rdchk(22'h12, 16'h0042);
    prog(22'h12, 16'h000f);
    rdchk(22'h12, 16'h0002);
    run(3'd4);
    `CHK(rd[ST_OVERLAY], 1'b0)
    rdchk(22'h12, 16'h0012);
  endtask
  task automatic t_lock;
    run(3'd3);
    run(3'd6);
    `CHK(rd[2:1], 2'b11)
    run(3'd1);
    `CHK(rd[ST_REFUSED], 1'b1)
    run(3'd4);
    run(3'd3);
    prog(22'h12, 16'h0000);
    rdchk(22'h12, 16'h0002);
    run(3'd4);
  endtask
  task automatic t_supply;
    run(3'd3);
    @(posedge clk);
    sok <= 1'b0;
    repeat (3) @(posedge clk);
    sok <= 1'b1;
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[ST_POWER_OK], rd[ST_OVERLAY]}, 2'b00)
    power_wait();
    rdchk(22'h12, 16'h0012);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole sequence needs about a thousand cycles
  initial
  begin
    #300000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    {rst, cyc, stb, we, adr, dat, sok, fac} = {4'b1000, 8'h00, 32'h0, 2'b10};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_early();
    t_query(1'b1);
    t_factory();
    t_query(1'b0);
    t_overlay();
    t_lock();
    t_supply();
    give_verdict();
  end
endmodule
